// ### common/pcd_pkg.sv
package pcd_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_EXT_ALERT = 8'h21;
    localparam logic [7:0] ADDR_COMMAND = 8'h23;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int FRS_ALERT_BIT = 0;
    localparam logic [7:0] EXT_ALERT_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    // vendor status bits 15, 14, 9 and 5 survive a stop command
    localparam logic [15:0] VENDOR_KEEP_MASK = 16'hC220;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WAKE = 8'h11;
    localparam logic [7:0] CMD_DETECT_OFF = 8'h22;
    localparam logic [7:0] CMD_DETECT_ON = 8'h33;
    localparam logic [7:0] CMD_STOP_SINK = 8'h44;
    localparam logic [7:0] CMD_START_SINK = 8'h55;
    localparam logic [7:0] CMD_STOP_SOURCE = 8'h66;
    localparam logic [7:0] CMD_SOURCE_DEFAULT = 8'h77;
    localparam logic [7:0] CMD_LOOK_CONNECT = 8'h99;
    localparam logic [7:0] CMD_RX_ONE_MORE = 8'hAA;
    localparam logic [7:0] CMD_RESET_TX_BUF = 8'hDD;
    localparam logic [7:0] CMD_RESET_RX_BUF = 8'hEE;
    localparam logic [7:0] CMD_IDLE = 8'hFF;

    // ------------------------------------------------------------
    // decoded command class, one-hot
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        PCD_CMD_NONE = 9'h001,
        PCD_CMD_NOP = 9'h002,
        PCD_CMD_DETECT_OFF = 9'h004,
        PCD_CMD_DETECT_ON = 9'h008,
        PCD_CMD_STOP_SINK = 9'h010,
        PCD_CMD_START_SINK = 9'h020,
        PCD_CMD_STOP_SOURCE = 9'h040,
        PCD_CMD_SOURCE_DEF = 9'h080,
        PCD_CMD_BAD = 9'h100
    } pcd_cmd_t;

endpackage : pcd_pkg

// ### rtl/pcd_command_decoder.sv
// Functional notes
// - fast role swap reception sets extended alert bit 0, else stays zero.
// - hot output asserted while role swap alert and its enable are both one.
// - writing one to the role swap alert bit clears it; zero leaves it.
// - hot output released when role swap alert and vendor hot bit are zero.
// - extended alert bits 7..1 read zero; host writes zero there.
// - wake command does nothing beyond waking the interface.
// - detect-off command disables present and safe-zero detection.
// - accepted detect-off clears the detection enable bit.
// - detect-off refused with interface error while sourcing or sinking.
// - detect-on refreshes present and safe-zero status, then enables detection.
// - stop-sinking ends sinking, no discharge, present detection stays on.
// - stop-sinking clears fault flags and vendor status except kept bits.
// - stop-sinking turns the sink gate drive off.
// - start-sinking enables sinking and present detection.
// - start-sinking refused with interface error while sourcing.
// - accepted start-sinking turns sink gate on and stops discharge.
// - while sinking, bus removal starts discharge if auto discharge set.
// - while sinking, sink open starts discharge if discharge on open set.
// - stop-sourcing ends sourcing and clears the same flags.
// - stop-sourcing turns source gate off and discharges to safe zero.
// - default sourcing enables safe five volt sourcing and present detection.
// - default sourcing refused with interface error while sinking.
// - interface error flag is write-one-clear, also set by undefined codes.
`timescale 1ns/1ps
module pcd_command_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic frs_received,
    input wire logic role_swap_hot_enable,
    input wire logic vendor_hot_status,
    input wire logic vbus_present_raw,
    input wire logic vsafe0v_raw,
    input wire logic vbus_removed,
    input wire logic sink_open_detected,
    input wire logic auto_discharge_disconnect,
    input wire logic discharge_on_open,
    input wire logic interface_error_clear,
    input wire logic processor_hot_n_in,
    output logic processor_hot_n_out,
    output logic processor_hot_n_oe,
    output logic sink_gate_drive,
    output logic source_gate_drive,
    output logic vbus_discharge,
    output logic detect_enable,
    output logic vbus_present_status,
    output logic vsafe0v_status,
    output logic detect_status_change,
    output logic interface_error_flag,
    output logic overcurrent_fault_clear,
    output logic overvoltage_fault_clear,
    output logic vendor_status_clear,
    output logic [15:0] vendor_keep_mask
);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // reg_wr marks the end of a whole byte write, so nothing acts
    // on a partly received command
    logic cmd_strobe;
    logic ext_strobe;
    pcd_pkg::pcd_cmd_t cmd_kind;
    logic cmd_refused;
    logic cmd_ok;

    assign cmd_strobe = reg_wr && (reg_addr == pcd_pkg::ADDR_COMMAND);
    assign ext_strobe = reg_wr && (reg_addr == pcd_pkg::ADDR_EXT_ALERT);

    always_comb begin
        case (reg_wdata)
            pcd_pkg::CMD_WAKE: cmd_kind = pcd_pkg::PCD_CMD_NOP;
            pcd_pkg::CMD_DETECT_OFF: cmd_kind = pcd_pkg::PCD_CMD_DETECT_OFF;
            pcd_pkg::CMD_DETECT_ON: cmd_kind = pcd_pkg::PCD_CMD_DETECT_ON;
            pcd_pkg::CMD_STOP_SINK: cmd_kind = pcd_pkg::PCD_CMD_STOP_SINK;
            pcd_pkg::CMD_START_SINK: cmd_kind = pcd_pkg::PCD_CMD_START_SINK;
            pcd_pkg::CMD_STOP_SOURCE: cmd_kind = pcd_pkg::PCD_CMD_STOP_SOURCE;
            pcd_pkg::CMD_SOURCE_DEFAULT: begin
                cmd_kind = pcd_pkg::PCD_CMD_SOURCE_DEF;
            end
            // served by other blocks; no effect here
            pcd_pkg::CMD_LOOK_CONNECT,
            pcd_pkg::CMD_RX_ONE_MORE,
            pcd_pkg::CMD_RESET_TX_BUF,
            pcd_pkg::CMD_RESET_RX_BUF,
            pcd_pkg::CMD_IDLE: cmd_kind = pcd_pkg::PCD_CMD_NOP;
            default: cmd_kind = pcd_pkg::PCD_CMD_BAD;
        endcase
    end

    // acceptance looks at the gate state as it stands now
    always_comb begin
        case (cmd_kind)
            pcd_pkg::PCD_CMD_DETECT_OFF: begin
                cmd_refused = sink_gate_drive || source_gate_drive;
            end
            pcd_pkg::PCD_CMD_START_SINK: begin
                cmd_refused = source_gate_drive;
            end
            pcd_pkg::PCD_CMD_SOURCE_DEF: begin
                cmd_refused = sink_gate_drive;
            end
            pcd_pkg::PCD_CMD_BAD: cmd_refused = 1'b1;
            default: cmd_refused = 1'b0;
        endcase
    end

    assign cmd_ok = cmd_strobe && !cmd_refused;

    // ------------------------------------------------------------
    // interface error flag
    // ------------------------------------------------------------
    // set beats clear so a refusal in the clearing cycle is kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interface_error_flag <= 1'b0;
        end else if (cmd_strobe && cmd_refused) begin
            interface_error_flag <= 1'b1;
        end else if (interface_error_clear) begin
            interface_error_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sink path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_gate_drive <= 1'b0;
        end else if (cmd_ok) begin
            case (cmd_kind)
                pcd_pkg::PCD_CMD_START_SINK: sink_gate_drive <= 1'b1;
                pcd_pkg::PCD_CMD_STOP_SINK: sink_gate_drive <= 1'b0;
                default: sink_gate_drive <= sink_gate_drive;
            endcase
        end
    end

    // ------------------------------------------------------------
    // source path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            source_gate_drive <= 1'b0;
        end else if (cmd_ok) begin
            case (cmd_kind)
                pcd_pkg::PCD_CMD_SOURCE_DEF: begin
                    source_gate_drive <= 1'b1;
                end
                pcd_pkg::PCD_CMD_STOP_SOURCE: begin
                    source_gate_drive <= 1'b0;
                end
                default: source_gate_drive <= source_gate_drive;
            endcase
        end
    end

    // ------------------------------------------------------------
    // vbus discharge
    // ------------------------------------------------------------
    // discharge ends by itself once the bus reads safe zero; the
    // stop-sinking command leaves the bus charged on purpose
    logic sink_auto_discharge;

    assign sink_auto_discharge = sink_gate_drive
        && ((vbus_removed && auto_discharge_disconnect)
        || (sink_open_detected && discharge_on_open));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vbus_discharge <= 1'b0;
        end else if (cmd_ok
                && (cmd_kind == pcd_pkg::PCD_CMD_STOP_SOURCE)) begin
            vbus_discharge <= 1'b1;
        end else if (cmd_ok && ((cmd_kind == pcd_pkg::PCD_CMD_START_SINK)
                || (cmd_kind == pcd_pkg::PCD_CMD_SOURCE_DEF))) begin
            vbus_discharge <= 1'b0;
        end else if (sink_auto_discharge) begin
            vbus_discharge <= 1'b1;
        end else if (vsafe0v_raw) begin
            vbus_discharge <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // detection enable and status
    // ------------------------------------------------------------
    // detect-on captures status in the same edge that enables detection, so
    // its first enabled value is fresh; start-sinking and default sourcing capture one edge later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detect_enable <= 1'b0;
        end else if (cmd_ok) begin
            case (cmd_kind)
                pcd_pkg::PCD_CMD_DETECT_OFF: detect_enable <= 1'b0;
                pcd_pkg::PCD_CMD_DETECT_ON: detect_enable <= 1'b1;
                pcd_pkg::PCD_CMD_START_SINK: detect_enable <= 1'b1;
                pcd_pkg::PCD_CMD_SOURCE_DEF: detect_enable <= 1'b1;
                // stop commands keep present detection running
                default: detect_enable <= detect_enable;
            endcase
        end
    end

    logic status_load;

    assign status_load = detect_enable
        || (cmd_ok && (cmd_kind == pcd_pkg::PCD_CMD_DETECT_ON));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vbus_present_status <= 1'b0;
            vsafe0v_status <= 1'b1;
        end else if (status_load) begin
            vbus_present_status <= vbus_present_raw;
            vsafe0v_status <= vsafe0v_raw;
        end
    end

    // change only reported once detection is running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detect_status_change <= 1'b0;
        end else begin
            detect_status_change <= detect_enable
                && ((vbus_present_raw != vbus_present_status)
                || (vsafe0v_raw != vsafe0v_status));
        end
    end

    // ------------------------------------------------------------
    // fault and vendor status clearing
    // ------------------------------------------------------------
    logic stop_clear;

    assign stop_clear = cmd_ok && ((cmd_kind == pcd_pkg::PCD_CMD_STOP_SINK)
        || (cmd_kind == pcd_pkg::PCD_CMD_STOP_SOURCE));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overcurrent_fault_clear <= 1'b0;
            overvoltage_fault_clear <= 1'b0;
            vendor_status_clear <= 1'b0;
        end else begin
            overcurrent_fault_clear <= stop_clear;
            overvoltage_fault_clear <= stop_clear;
            vendor_status_clear <= stop_clear;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vendor_keep_mask <= pcd_pkg::VENDOR_KEEP_MASK;
        end else begin
            vendor_keep_mask <= pcd_pkg::VENDOR_KEEP_MASK;
        end
    end

    // ------------------------------------------------------------
    // extended alert
    // ------------------------------------------------------------
    // a swap arriving in the clearing cycle is kept
    logic frs_alert_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frs_alert_reg <= pcd_pkg::EXT_ALERT_RESET[pcd_pkg::FRS_ALERT_BIT];
        end else if (frs_received) begin
            frs_alert_reg <= 1'b1;
        end else if (ext_strobe && reg_wdata[pcd_pkg::FRS_ALERT_BIT]) begin
            frs_alert_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // processor hot pin
    // ------------------------------------------------------------
    // open drain: only ever pulls low, follows the alert by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            processor_hot_n_oe <= 1'b0;
            processor_hot_n_out <= 1'b0;
        end else begin
            processor_hot_n_oe <= (frs_alert_reg && role_swap_hot_enable)
                || vendor_hot_status;
            processor_hot_n_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    // command register and unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= pcd_pkg::RDATA_RESET;
        end else if (reg_rd) begin
            if (reg_addr == pcd_pkg::ADDR_EXT_ALERT) begin
                reg_rdata <= {7'h00, frs_alert_reg};
            end else begin
                reg_rdata <= pcd_pkg::RDATA_RESET;
            end
        end
    end

endmodule : pcd_command_decoder

// ### testbench/pcd_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port-level checks of the command decoder
// ------------------------------------------------------------
module pcd_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic frs_received,
    input wire logic role_swap_hot_enable,
    input wire logic vendor_hot_status,
    input wire logic vbus_present_raw,
    input wire logic vsafe0v_raw,
    input wire logic processor_hot_n_out,
    input wire logic processor_hot_n_oe,
    input wire logic sink_gate_drive,
    input wire logic source_gate_drive,
    input wire logic vbus_discharge,
    input wire logic detect_enable,
    input wire logic vbus_present_status,
    input wire logic vsafe0v_status,
    input wire logic interface_error_flag,
    input wire logic overcurrent_fault_clear,
    input wire logic overvoltage_fault_clear,
    input wire logic vendor_status_clear
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic cmd_wr;
    assign cmd_wr = reg_wr && reg_addr == 8'h23;
    sequence s_src_off;
        !source_gate_drive && vbus_discharge;
    endsequence
    // clear pulses may trail the gate change by one cycle
    sequence s_clears;
        overcurrent_fault_clear && overvoltage_fault_clear
            && vendor_status_clear;
    endsequence
    a_hot_assert: assert property (frs_received && role_swap_hot_enable
        ##1 role_swap_hot_enable |-> ##1 processor_hot_n_oe)
        else $error("hot output not asserted after role swap");
    a_hot_release: assert property (
        (!role_swap_hot_enable && !vendor_hot_status) [*2]
        |-> ##1 !processor_hot_n_oe && !processor_hot_n_out)
        else $error("hot output not released");
    a_start_sink: assert property (cmd_wr && reg_wdata == 8'h55
        && !source_gate_drive && !sink_gate_drive
        |=> sink_gate_drive && detect_enable && !vbus_discharge)
        else $error("start sinking not applied");
    a_sink_refused: assert property (cmd_wr && reg_wdata == 8'h55
        && source_gate_drive
        |=> interface_error_flag && !sink_gate_drive && source_gate_drive)
        else $error("start sinking not refused");
    a_stop_sink: assert property (cmd_wr && reg_wdata == 8'h44
        |=> !sink_gate_drive && $stable(detect_enable) ##[0:1] s_clears)
        else $error("stop sinking wrong");
    a_stop_source: assert property (cmd_wr && reg_wdata == 8'h66
        |=> s_src_off ##[0:1] s_clears)
        else $error("stop sourcing wrong");
    a_detect_off: assert property (cmd_wr && reg_wdata == 8'h22
        && !sink_gate_drive && !source_gate_drive |=> !detect_enable)
        else $error("detection not disabled");
    a_detect_kept: assert property (cmd_wr && reg_wdata == 8'h22
        && (sink_gate_drive || source_gate_drive)
        |=> interface_error_flag && detect_enable)
        else $error("detect off not refused");
    a_detect_on: assert property (cmd_wr && reg_wdata == 8'h33
        |=> detect_enable && vbus_present_status == $past(vbus_present_raw)
        && vsafe0v_status == $past(vsafe0v_raw))
        else $error("detect on status not refreshed");
    a_source_refused: assert property (cmd_wr && reg_wdata == 8'h77
        && sink_gate_drive |=> interface_error_flag && !source_gate_drive)
        else $error("default sourcing not refused");
    a_bad_code: assert property (cmd_wr
        && (reg_wdata == 8'h88 || reg_wdata == 8'hCC)
        |=> interface_error_flag)
        else $error("undefined code not flagged");
    a_wake_nop: assert property (cmd_wr && reg_wdata == 8'h11
        |=> $stable(sink_gate_drive) && $stable(source_gate_drive)
        && $stable(detect_enable))
        else $error("wake command changed state");
endmodule : pcd_props

bind pcd_command_decoder pcd_props u_props (.clk, .rst_n, .reg_wr,
    .reg_addr, .reg_wdata, .frs_received, .role_swap_hot_enable,
    .vendor_hot_status, .vbus_present_raw, .vsafe0v_raw,
    .processor_hot_n_out, .processor_hot_n_oe, .sink_gate_drive,
    .source_gate_drive, .vbus_discharge, .detect_enable,
    .vbus_present_status, .vsafe0v_status, .interface_error_flag,
    .overcurrent_fault_clear, .overvoltage_fault_clear,
    .vendor_status_clear);

// ### testbench/pcd_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port manager side of the register bus
// ------------------------------------------------------------
module pcd_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == 8'h21) ? (d & 8'h01) : d;
        @(posedge clk);
        reg_wr <= 1'b0;
        // stale data inverted so nothing relies on it after the write
        reg_wdata <= ~reg_wdata;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : pcd_host_model

// ### testbench/port_controller_command_decoder_tb.sv
`timescale 1ns/1ps
module port_controller_command_decoder_tb;
    logic clk, rst_n, reg_wr, reg_rd, hot_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data;
    logic frs_received, role_swap_hot_enable, vendor_hot_status;
    logic vbus_present_raw, vsafe0v_raw, vbus_removed, sink_open_detected;
    logic auto_discharge_disconnect, discharge_on_open, interface_error_clear;
    logic processor_hot_n_out, processor_hot_n_oe, sink_gate_drive;
    logic source_gate_drive, vbus_discharge, detect_enable;
    logic vbus_present_status, vsafe0v_status, detect_status_change;
    logic interface_error_flag, overcurrent_fault_clear;
    logic overvoltage_fault_clear, vendor_status_clear;
    logic [15:0] vendor_keep_mask;
    int num_errors = 0;
    int n_compared = 0;
    // pulled up on the board; the device only ever pulls it low
    assign hot_pin = processor_hot_n_oe ? processor_hot_n_out : 1'b1;
    pcd_command_decoder uut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .frs_received, .role_swap_hot_enable,
        .vendor_hot_status, .vbus_present_raw, .vsafe0v_raw, .vbus_removed,
        .sink_open_detected, .auto_discharge_disconnect, .discharge_on_open,
        .interface_error_clear, .processor_hot_n_in(hot_pin),
        .processor_hot_n_out, .processor_hot_n_oe, .sink_gate_drive,
        .source_gate_drive, .vbus_discharge, .detect_enable,
        .vbus_present_status, .vsafe0v_status, .detect_status_change,
        .interface_error_flag, .overcurrent_fault_clear,
        .overvoltage_fault_clear, .vendor_status_clear, .vendor_keep_mask);
    pcd_host_model host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic cmd(input logic [7:0] c);
        host.wr(8'h23, c);
        #1;
    endtask : cmd
    task automatic clr_err();
        step(1);
        interface_error_clear <= 1'b1;
        step(1);
        interface_error_clear <= 1'b0;
        #1;
        chk("err_clear", 0, interface_error_flag);
    endtask : clr_err
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("rst_out", 16'h0001, {sink_gate_drive, vsafe0v_status});
        chk("keep_mask", 16'hC220, vendor_keep_mask);
        host.rd(8'h21, rd_data);
        chk("alert_rst", 8'h00, rd_data);
        host.rd(8'h23, rd_data);
        chk("cmd_rd", 8'h00, rd_data);
        host.rd(8'h30, rd_data);
        chk("unmapped_rd", 8'h00, rd_data);
    endtask : t_reset
    task automatic t_sink();
        cmd(8'h55);
        chk("sink_on", 3'b110,
            {sink_gate_drive, detect_enable, vbus_discharge});
        cmd(8'h77);
        chk("src_refused", 2'b10,
            {interface_error_flag, source_gate_drive});
        clr_err();
        cmd(8'h22);
        chk("det_kept", 2'b11, {interface_error_flag, detect_enable});
        clr_err();
        cmd(8'h44);
        chk("sink_off", 3'b010,
            {sink_gate_drive, detect_enable, vbus_discharge});
        chk("snk_clr_pulse", 3'b111, {overcurrent_fault_clear,
            overvoltage_fault_clear, vendor_status_clear});
    endtask : t_sink
    task automatic t_discharge();
        cmd(8'h55);
        step(1);
        vbus_removed <= 1'b1;
        step(2);
        #1;
        chk("no_auto", 0, vbus_discharge);
        step(1);
        discharge_on_open <= 1'b1;
        sink_open_detected <= 1'b1;
        step(2);
        #1;
        chk("open_dis", 1, vbus_discharge);
        step(1);
        sink_open_detected <= 1'b0;
        cmd(8'h55);
        chk("dis_stop", 0, vbus_discharge);
        step(1);
        auto_discharge_disconnect <= 1'b1;
        step(2);
        #1;
        chk("auto_dis", 1, vbus_discharge);
        step(1);
        vbus_removed <= 1'b0;
        cmd(8'h44);
        chk("dis_kept", 2'b01, {sink_gate_drive, vbus_discharge});
    endtask : t_discharge
    task automatic t_source();
        cmd(8'h77);
        chk("src_on", 3'b110,
            {source_gate_drive, detect_enable, vbus_discharge});
        cmd(8'h55);
        chk("snk_refused", 3'b101, {interface_error_flag,
            sink_gate_drive, source_gate_drive});
        clr_err();
        cmd(8'h66);
        chk("src_off", 2'b01, {source_gate_drive, vbus_discharge});
        chk("src_clr_pulse", 3'b111, {overcurrent_fault_clear,
            overvoltage_fault_clear, vendor_status_clear});
        step(1);
        vsafe0v_raw <= 1'b1;
        step(2);
        #1;
        chk("dis_done", 0, vbus_discharge);
    endtask : t_source
    task automatic t_detect();
        cmd(8'h22);
        chk("det_off", 2'b00, {interface_error_flag, detect_enable});
        step(1);
        vbus_present_raw <= 1'b1;
        vsafe0v_raw <= 1'b0;
        cmd(8'h33);
        chk("det_on", 3'b110,
            {detect_enable, vbus_present_status, vsafe0v_status});
        step(1);
        vbus_present_raw <= 1'b0;
        step(1);
        #1;
        chk("det_change", 1, detect_status_change);
    endtask : t_detect
    task automatic t_codes();
        logic [7:0] codes [8] = '{8'h11, 8'h99, 8'hAA, 8'hDD, 8'hEE,
            8'hFF, 8'h88, 8'hCC};
        foreach (codes[i]) begin
            clr_err();
            cmd(codes[i]);
            chk("code_err", i >= 6, interface_error_flag);
            chk("code_state", 3'b001,
                {sink_gate_drive, source_gate_drive, detect_enable});
        end
    endtask : t_codes
    task automatic t_alert();
        step(1);
        role_swap_hot_enable <= 1'b1;
        frs_received <= 1'b1;
        step(1);
        frs_received <= 1'b0;
        step(1);
        #1;
        chk("hot_on", 0, hot_pin);
        host.rd(8'h21, rd_data);
        chk("alert_set", 8'h01, rd_data);
        host.wr(8'h21, 8'hFE);
        host.rd(8'h21, rd_data);
        chk("alert_kept", 8'h01, rd_data);
        host.wr(8'h21, 8'h01);
        step(1);
        #1;
        chk("hot_off", 1, hot_pin);
        host.rd(8'h21, rd_data);
        chk("alert_clr", 8'h00, rd_data);
        vendor_hot_status <= 1'b1;
        step(2);
        #1;
        chk("vendor_hot", 0, hot_pin);
        step(1);
        vendor_hot_status <= 1'b0;
        step(2);
        #1;
        chk("hot_rel", 1, hot_pin);
    endtask : t_alert
    initial begin
        {rst_n, frs_received, role_swap_hot_enable, vendor_hot_status,
            vbus_present_raw, vsafe0v_raw, vbus_removed, sink_open_detected,
            auto_discharge_disconnect, discharge_on_open,
            interface_error_clear} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_sink();
        t_discharge();
        t_source();
        t_detect();
        t_codes();
        t_alert();
        close_out();
    end
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
endmodule : port_controller_command_decoder_tb
